// File: rtl/cso_device.sv
// output module end: mode, slew limiter, scaling and fail-safe control
// assumes link strobes are synchronous to i_ref_clk, front-end flags too
//
// Contract
// [RL1] mode bit 5: 4..20 mA, codes 0..32767
// [RL2] mode bit 4: 0..20 mA, codes 0..32767
// [RL3] mode bit 7: 0..20 mA, unsigned 0..65535
// [RL4] mode bit 6: 0..24 mA, codes 0..24000
// [RL5] mode bit 1 set disables converter checking
// [RL6] mode bit 0 enables channel; others reserved
// [RL7] slew bits 0-2: step of 2^code LSB
// [RL8] slew bits 8-11: sixteen update rates
// [RL9] slew bit 15 enables ramp, else jump
// [RL10] written output value drives matching current
// [RL11] zero output value turns indicator off
// [RL12] health bits: open 2, hot 3, supply 7
// [RL13] control bit 0: 1 normal, 0 fail-safe
// [RL14] master sets normal bit when starting channels
// [RL15] fail-safe event clears normal, substitutes output
// [RL16] fail-safe held until normal bit received
// [RL17] after restart master sets normal bit again
// [RL18] first good transfer with bit restores normal
// [RL19] fs mode 0 static, 1 hold last
// [RL20] static mode drives fail-safe value register
// [RL21] fail-safe value used only after first start
// [RL22] bus cycle no shorter than 200 us
// [RL23] at most one scaling bit set
`timescale 1ns/100ps
module cso_device #(
   parameter int LOSS_CYCLES = cso_pkg::CSO_LOSS_CYCLES // link watchdog
) (
   // clock, reset, enable
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // link to the bus master
   cso_link_if.device lnk,
   // converter front end status
   input wire logic [1:0] i_open_line,
   input wire logic [1:0] i_overtemp,
   input wire logic i_supply_fault,
   // converter drive and indicators
   output logic [1:0][15:0] o_dac_code,
   output logic [1:0] o_dac_en,
   output logic [1:0] o_ch_led,
   output logic o_failsafe_active
);
   import cso_pkg::*;

   // ****************************************************************
   // link watchdog and fail-safe state
   // ****************************************************************
   cso_state_t state_q; // fail-safe state
   cso_state_t state_d;
   logic [31:0] wdog_q; // cycles since the last cyclic transfer
   wire normal_req = lnk.fs_ctrl[CSO_FSC_NORMAL]; // RL13
   wire comm_lost = (wdog_q == 32'(LOSS_CYCLES - 1)); // silence too long
   wire run_start = lnk.cyc_valid & normal_req;

   // watchdog restarts on each transfer and saturates at the limit
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wdog_q <= 32'h0;
      end else if (i_ce) begin
         if (lnk.cyc_valid) begin
            wdog_q <= 32'h0;
         end else if (!comm_lost) begin
            wdog_q <= wdog_q + 32'h1;
         end
      end
   end

   // next fail-safe state
   always_comb begin
      state_d = state_q;
      case (state_q)
         CSO_ST_INIT: begin
            if (run_start) begin // RL14
               state_d = CSO_ST_RUN;
            end
         end
         CSO_ST_RUN: begin
            // loss or an explicit request both count as an event
            if (comm_lost || (lnk.cyc_valid && !normal_req)) begin
               state_d = CSO_ST_FS; // RL15
            end
         end
         CSO_ST_FS: begin
            // recovered traffic alone does not leave fail-safe
            if (run_start) begin // RL16 RL18
               state_d = CSO_ST_RUN;
            end
         end
         default: begin
            state_d = CSO_ST_INIT;
         end
      endcase
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= CSO_ST_INIT;
      end else if (i_ce) begin
         state_q <= state_d;
      end
   end

   wire st_run = (state_q == CSO_ST_RUN);
   wire st_fs = (state_q == CSO_ST_FS);
   assign lnk.module_ok = st_run; // internal normal-operation bit
   assign o_failsafe_active = st_fs;

   // ****************************************************************
   // per-channel registers, limiter and scaling
   // ****************************************************************
   for (genvar ch = 0; ch < CSO_NCH; ch++) begin : g_ch
      logic [15:0] mode_q; // channel mode word
      logic [15:0] slew_q; // limiter configuration
      logic [7:0] fsmode_q; // fail-safe mode
      logic [15:0] fsval_q; // fail-safe static value
      logic [15:0] target_q; // last cyclic output value
      logic [15:0] last_q; // last value accepted in normal operation
      logic [15:0] ramp_q; // limited normalized value
      logic [15:0] tick_q; // limiter rate divider
      logic [15:0] dac_q; // converter code
      logic [7:0] health_q; // health byte
      logic led_q; // channel indicator

      // configuration decode
      wire wr_mode = lnk.cfg_wr & (lnk.cfg_addr == CSO_ADR_MODE[ch]);
      wire wr_slew = lnk.cfg_wr & (lnk.cfg_addr == CSO_ADR_SLEW[ch]);
      wire wr_fsm = lnk.cfg_wr & (lnk.cfg_addr == CSO_ADR_FSMODE[ch]);
      wire wr_fsv = lnk.cfg_wr & (lnk.cfg_addr == CSO_ADR_FSVAL[ch]);

      wire en = mode_q[CSO_MODE_EN]; // RL6
      wire uns = mode_q[CSO_MODE_S020U]; // RL3
      wire [15:0] vmax = mode_q[CSO_MODE_S024] ? CSO_MAX_24
         : CSO_MAX_INT; // RL4

      // demand per state: static value only once started
      wire [15:0] fs_out = (fsmode_q == CSO_FSMODE_RST) ? fsval_q
         : last_q; // RL19 RL20
      wire [15:0] demand = !en ? 16'h0 : st_run ? target_q
         : st_fs ? fs_out : 16'h0; // RL21

      // signed modes drop negatives and clamp to the range top
      wire [15:0] clamped = uns ? demand : demand[15] ? 16'h0
         : (demand > vmax) ? vmax : demand; // RL10

      // limiter step and rate
      wire [15:0] step = 16'h1 << slew_q[CSO_SLEW_STEP_LO +: 3]; // RL7
      wire [15:0] period = 16'(CSO_RATE_CYC[
         slew_q[CSO_SLEW_RATE_LO +: 4]] - 1); // RL8
      wire tick = (tick_q >= period);
      wire [15:0] up_gap = clamped - ramp_q;
      wire [15:0] dn_gap = ramp_q - clamped;
      wire [15:0] ramp_up = (up_gap > step) ? ramp_q + step : clamped;
      wire [15:0] ramp_dn = (dn_gap > step) ? ramp_q - step : clamped;
      wire [15:0] ramp_d = !slew_q[CSO_SLEW_EN] ? clamped // RL9
         : !tick ? ramp_q
         : (clamped > ramp_q) ? ramp_up : ramp_dn;

      // scaling onto the 0..24 mA converter code
      wire [33:0] p420 = 34'(ramp_q) * 34'(CSO_K_420);
      wire [33:0] p020 = 34'(ramp_q) * 34'(CSO_K_020);
      wire [33:0] p020u = 34'(ramp_q) * 34'(CSO_K_020U);
      wire [33:0] p024 = 34'(ramp_q) * 34'(CSO_K_024);
      // 24000 lands one count past the top code, so saturate there
      wire [15:0] p024_sat = (|p024[33:32]) ? 16'hffff : p024[31:16];
      wire [15:0] dac_d = mode_q[CSO_MODE_S020U] ? p020u[31:16] // RL3
         : mode_q[CSO_MODE_S024] ? p024_sat // RL4
         : mode_q[CSO_MODE_S020] ? p020[30:15] // RL2
         : mode_q[CSO_MODE_S420] ? CSO_DAC_4MA + p420[30:15] // RL1
         : 16'h0; // no scaling chosen leaves the output at zero

      // health byte: reserved bits stay zero
      wire ovt_chk = i_overtemp[ch] & ~mode_q[CSO_MODE_NOCHK]; // RL5
      wire [7:0] health_d = 8'(({7'h0, i_open_line[ch] & en}
         << CSO_HL_OPEN) | ({7'h0, ovt_chk & en} << CSO_HL_OVT)
         | ({7'h0, i_supply_fault} << CSO_HL_SUP)); // RL12

      // configuration registers, written only through the link
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            mode_q <= CSO_MODE_RST;
            slew_q <= CSO_SLEW_RST;
            fsmode_q <= CSO_FSMODE_RST;
            fsval_q <= CSO_FSVAL_RST;
         end else if (i_ce) begin
            if (wr_mode) begin
               mode_q <= lnk.cfg_wdata; // reserved bits kept, unused
            end
            if (wr_slew) begin
               slew_q <= lnk.cfg_wdata;
            end
            if (wr_fsm) begin
               fsmode_q <= lnk.cfg_wdata[7:0];
            end
            if (wr_fsv) begin
               fsval_q <= lnk.cfg_wdata;
            end
         end
      end

      // cyclic value, held value and limiter state
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            target_q <= 16'h0;
            last_q <= 16'h0;
            ramp_q <= 16'h0;
            tick_q <= 16'h0;
         end else if (i_ce) begin
            if (lnk.cyc_valid) begin
               target_q <= lnk.value[ch]; // RL10
            end
            if (st_run) begin
               last_q <= target_q; // RL19
            end
            tick_q <= tick ? 16'h0 : tick_q + 16'h1;
            ramp_q <= ramp_d;
         end
      end

      // registered outputs
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            dac_q <= 16'h0;
            health_q <= 8'h0;
            led_q <= 1'b0;
         end else if (i_ce) begin
            dac_q <= dac_d;
            health_q <= health_d;
            led_q <= en & (demand != 16'h0); // RL11
         end
      end

      assign o_dac_code[ch] = dac_q;
      assign o_dac_en[ch] = en;
      assign o_ch_led[ch] = led_q;
      assign lnk.health[ch] = health_q;
   end

endmodule : cso_device

// File: rtl/cso_host.sv
// bus master end: cyclic frame generator, normal-operation bit, config
// assumes the application gives one-cycle requests on i_ref_clk
`timescale 1ns/100ps
module cso_host #(
   parameter int CYCLE_CYCLES = cso_pkg::CSO_MIN_CYCLE_CYC // bus cycle
) (
   // clock, reset, enable
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // application: run control and cyclic values
   input wire logic i_start,
   input wire logic i_restart,
   input wire logic [1:0][15:0] i_value,
   // application: configuration writes
   input wire logic i_cfg_req,
   input wire logic [8:0] i_cfg_addr,
   input wire logic [15:0] i_cfg_data,
   output logic o_cfg_ready,
   output logic o_cfg_refused,
   // application: feedback
   output logic [1:0][7:0] o_health,
   output logic o_module_ok,
   output logic o_cycle_strobe,
   // link to the module
   cso_link_if.host lnk
);
   import cso_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   logic run_q; // normal-operation request bit
   logic [31:0] cnt_q; // bus cycle counter
   logic cyc_q; // cyclic transfer strobe
   logic [1:0][15:0] value_q; // values sent in the frame
   logic wr_q; // configuration write strobe
   logic [8:0] addr_q;
   logic [15:0] data_q;
   logic refused_q;
   logic [1:0][7:0] health_q;
   logic ok_q;

   // a mode word with more than one scaling bit is not sent
   wire is_mode = (i_cfg_addr == CSO_ADR_MODE[0])
      | (i_cfg_addr == CSO_ADR_MODE[1]);
   wire [3:0] scal = i_cfg_data[CSO_MODE_S020U:CSO_MODE_S020];
   wire multi = (scal & (scal - 4'h1)) != 4'h0;
   wire bad = is_mode & multi; // RL23
   wire cyc_end = (cnt_q == 32'(CYCLE_CYCLES - 1)); // RL22
   assign o_cfg_ready = ~wr_q; // one write per two cycles

   // ****************************************************************
   // cyclic frame and normal-operation bit
   // ****************************************************************
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         run_q <= 1'b0;
         cnt_q <= 32'h0;
         cyc_q <= 1'b0;
         value_q <= '0;
      end else if (i_ce) begin
         // start wins over a restart in the same cycle
         if (i_start) begin
            run_q <= 1'b1; // RL14 RL17
         end else if (i_restart) begin
            run_q <= 1'b0;
         end
         cnt_q <= cyc_end ? 32'h0 : cnt_q + 32'h1;
         cyc_q <= cyc_end;
         if (cyc_end) begin
            value_q <= i_value;
         end
      end
   end

   // ****************************************************************
   // configuration writes and feedback
   // ****************************************************************
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_q <= 1'b0;
         addr_q <= 9'h0;
         data_q <= 16'h0;
         refused_q <= 1'b0;
         health_q <= '0;
         ok_q <= 1'b0;
      end else if (i_ce) begin
         wr_q <= i_cfg_req & o_cfg_ready & ~bad;
         refused_q <= i_cfg_req & o_cfg_ready & bad;
         if (i_cfg_req && o_cfg_ready) begin
            addr_q <= i_cfg_addr;
            data_q <= i_cfg_data;
         end
         health_q <= lnk.health;
         ok_q <= lnk.module_ok;
      end
   end

   assign lnk.cyc_valid = cyc_q & i_ce;
   assign lnk.value = value_q;
   assign lnk.fs_ctrl = {7'h0, run_q}; // RL13
   assign lnk.cfg_wr = wr_q & i_ce;
   assign lnk.cfg_addr = addr_q;
   assign lnk.cfg_wdata = data_q;
   assign o_cfg_refused = refused_q;
   assign o_health = health_q;
   assign o_module_ok = ok_q;
   assign o_cycle_strobe = cyc_q;

endmodule : cso_host

// File: rtl/cso_link_if.sv
// cyclic and configuration link between bus master and output module
// assumes both ends share i_ref_clk; all strobes are one-cycle pulses
`timescale 1ns/100ps
interface cso_link_if;
   logic cyc_valid; // cyclic transfer strobe
   logic [1:0][15:0] value; // normalized output per channel
   logic [7:0] fs_ctrl; // fail-safe control byte
   logic cfg_wr; // configuration write strobe
   logic [8:0] cfg_addr; // configuration address
   logic [15:0] cfg_wdata; // configuration data
   logic [1:0][7:0] health; // channel health bytes
   logic module_ok; // module in normal operation

   modport host (output cyc_valid, value, fs_ctrl, cfg_wr, cfg_addr,
      cfg_wdata, input health, module_ok);
   modport device (input cyc_valid, value, fs_ctrl, cfg_wr, cfg_addr,
      cfg_wdata, output health, module_ok);
endinterface : cso_link_if

// File: rtl/cso_pkg.sv
// constants shared by both ends of the current-output control link
// assumes a single 100 MHz clock on both ends and the two-channel build
package cso_pkg;

   // ****************************************************************
   // sizes and clock
   // ****************************************************************
   localparam int CSO_NCH = 2; // isolated output channels
   localparam int CSO_CLK_HZ = 100_000_000; // reference clock rate
   localparam int CSO_ADR_W = 9; // configuration address width

   // ****************************************************************
   // configuration addresses, one per channel
   // ****************************************************************
   localparam logic [8:0] CSO_ADR_MODE [2] = '{9'h182, 9'h18a};
   localparam logic [8:0] CSO_ADR_SLEW [2] = '{9'h186, 9'h18e};
   localparam logic [8:0] CSO_ADR_FSMODE [2] = '{9'h191, 9'h193};
   localparam logic [8:0] CSO_ADR_FSVAL [2] = '{9'h022, 9'h024};

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [15:0] CSO_MODE_RST = 16'h0021; // enabled, 4..20 mA
   localparam logic [15:0] CSO_SLEW_RST = 16'h0202; // 4 lsb, rate 2
   localparam logic [7:0] CSO_FSMODE_RST = 8'h00; // static substitute
   localparam logic [15:0] CSO_FSVAL_RST = 16'h0000;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CSO_MODE_EN = 0; // channel enable
   localparam int CSO_MODE_NOCHK = 1; // converter checking off
   localparam int CSO_MODE_S020 = 4; // 0..20 mA, 0..32767
   localparam int CSO_MODE_S420 = 5; // 4..20 mA, 0..32767
   localparam int CSO_MODE_S024 = 6; // 0..24 mA, 0..24000
   localparam int CSO_MODE_S020U = 7; // 0..20 mA, 0..65535 unsigned
   localparam int CSO_SLEW_STEP_LO = 0; // 3-bit step exponent
   localparam int CSO_SLEW_RATE_LO = 8; // 4-bit rate select
   localparam int CSO_SLEW_EN = 15; // ramp limiter on
   localparam int CSO_HL_OPEN = 2; // open line
   localparam int CSO_HL_OVT = 3; // converter too hot
   localparam int CSO_HL_SUP = 7; // module supply fault
   localparam int CSO_FSC_NORMAL = 0; // normal-operation request

   // ****************************************************************
   // value ranges and scaling onto a 0..24 mA 16-bit converter code
   // ****************************************************************
   localparam logic [15:0] CSO_MAX_INT = 16'h7fff;
   localparam logic [15:0] CSO_MAX_24 = 16'h5dc0; // 24000
   localparam logic [15:0] CSO_DAC_4MA = 16'h2aab; // 4 mA offset
   localparam logic [17:0] CSO_K_420 = 18'h0aaab; // shift 15
   localparam logic [17:0] CSO_K_020 = 18'h0d556; // shift 15
   localparam logic [17:0] CSO_K_020U = 18'h0d555; // shift 16
   localparam logic [17:0] CSO_K_024 = 18'h2bb0d; // shift 16

   // ****************************************************************
   // limiter update rates in hz and their periods in clock cycles
   // ****************************************************************
   localparam int CSO_RATE_HZ [16] = '{257730, 198410, 152440, 131580,
      115740, 69440, 37590, 25770, 20160, 16030, 10290, 8280, 6900,
      5530, 4240, 3300};
   localparam int CSO_RATE_CYC [16] = '{
      CSO_CLK_HZ / CSO_RATE_HZ[0], CSO_CLK_HZ / CSO_RATE_HZ[1],
      CSO_CLK_HZ / CSO_RATE_HZ[2], CSO_CLK_HZ / CSO_RATE_HZ[3],
      CSO_CLK_HZ / CSO_RATE_HZ[4], CSO_CLK_HZ / CSO_RATE_HZ[5],
      CSO_CLK_HZ / CSO_RATE_HZ[6], CSO_CLK_HZ / CSO_RATE_HZ[7],
      CSO_CLK_HZ / CSO_RATE_HZ[8], CSO_CLK_HZ / CSO_RATE_HZ[9],
      CSO_CLK_HZ / CSO_RATE_HZ[10], CSO_CLK_HZ / CSO_RATE_HZ[11],
      CSO_CLK_HZ / CSO_RATE_HZ[12], CSO_CLK_HZ / CSO_RATE_HZ[13],
      CSO_CLK_HZ / CSO_RATE_HZ[14], CSO_CLK_HZ / CSO_RATE_HZ[15]};

   // ****************************************************************
   // bus cycle timing
   // ****************************************************************
   localparam int CSO_MIN_CYCLE_US = 200; // shortest bus cycle
   localparam int CSO_MIN_CYCLE_CYC =
      CSO_MIN_CYCLE_US * (CSO_CLK_HZ / 1_000_000);
   localparam int CSO_LOSS_CYCLES = 3 * CSO_MIN_CYCLE_CYC; // 3 missed

   // ****************************************************************
   // fail-safe state, one-hot
   // ****************************************************************
   typedef enum logic [2:0] {
      CSO_ST_INIT = 3'b001, // never started, nothing substituted yet
      CSO_ST_RUN = 3'b010, // normal operation
      CSO_ST_FS = 3'b100 // fail-safe output
   } cso_state_t;

endpackage : cso_pkg

// File: testbench/cso_link_monitor.sv
// checker for the link between the host end and the device end
// assumes it sits beside the link interface, on the same clock and reset
`timescale 1ns/100ps
module cso_link_monitor #(
   parameter int LOSS_CYCLES = 50 // device link watchdog
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // link signals
   input wire logic cyc_valid,
   input wire logic [1:0][15:0] value,
   input wire logic [7:0] fs_ctrl,
   input wire logic cfg_wr,
   input wire logic [8:0] cfg_addr,
   input wire logic [15:0] cfg_wdata,
   input wire logic [1:0][7:0] health,
   input wire logic module_ok
);
   // ****************************************************************
   // helper: cycles since the last frame
   // ****************************************************************
   logic [15:0] gap_q; // saturates so a long stall never wraps
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         gap_q <= '0;
      end else if (cyc_valid) begin
         gap_q <= '0;
      end else if (gap_q != 16'hffff) begin
         gap_q <= gap_q + 16'h0001;
      end
   end

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);

   // ****************************************************************
   // properties
   // ****************************************************************
   property p_rsv_zero; fs_ctrl[7:1] == 7'h00; endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("control byte reserved bits set");
   property p_fs_normal; cyc_valid && fs_ctrl[0] |=> module_ok; endproperty
   a_fs_normal: assert property (p_fs_normal)
      else $error("normal frame did not restore normal operation");
   property p_fs_enter; cyc_valid && !fs_ctrl[0] |=> !module_ok; endproperty
   a_fs_enter: assert property (p_fs_enter)
      else $error("fail-safe request ignored");
   property p_ok_cause;
      $rose(module_ok) |-> $past(cyc_valid) && $past(fs_ctrl[0]);
   endproperty
   a_ok_cause: assert property (p_ok_cause)
      else $error("normal operation without a normal frame");
   property p_spacing; cyc_valid |=> !cyc_valid [*8]; endproperty
   a_spacing: assert property (p_spacing)
      else $error("frames too close");
   property p_loss; gap_q == LOSS_CYCLES + 3 |-> !module_ok; endproperty
   a_loss: assert property (p_loss)
      else $error("link loss did not enter fail-safe");
   property p_health_rsv;
      (health[0] & 8'h73) == 8'h00 && (health[1] & 8'h73) == 8'h00;
   endproperty
   a_health_rsv: assert property (p_health_rsv)
      else $error("health reserved bits set");
   property p_value_hold; cyc_valid |=> $stable(value) [*8]; endproperty
   a_value_hold: assert property (p_value_hold)
      else $error("output values changed inside a bus cycle");
endmodule : cso_link_monitor

// File: testbench/current_output_slew_fallback_test.sv
// self-checking bench: host end and device end joined by the link
// assumes the design package, interface and both ends are compiled first
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR at %0t: got %0h expected %0h", $time, g, e); end end
module current_output_slew_fallback_test;
   import cso_pkg::*;
   typedef struct packed {logic [15:0] m; logic [15:0] v; logic [15:0] d;
      logic l;} cso_row_t;
   // mode word and demand, then the converter code and indicator they give
   cso_row_t rows [8] = '{'{16'h0021, 16'h4000, 16'h8000, 1'b1},
      '{16'h0011, 16'h7fff, 16'hd554, 1'b1},
      '{16'h0041, 16'h5dc0, 16'hffff, 1'b1},
      '{16'h0041, 16'h7fff, 16'hffff, 1'b1},
      '{16'h0081, 16'hffff, 16'hd554, 1'b1},
      '{16'h0021, 16'h8000, 16'h2aab, 1'b1},
      '{16'h0020, 16'h1234, 16'h2aab, 1'b0},
      '{16'h0021, 16'h0000, 16'h2aab, 1'b0}};
   logic clk = 1'b0, rst_n = 1'b0, host_ce = 1'b1, start = 1'b0;
   logic restart = 1'b0, cfg_req = 1'b0, cfg_refused, refd, supply = 1'b0;
   logic fs_act, module_ok;
   logic [1:0][15:0] value = '0, dac;
   logic [8:0] cfg_addr = '0;
   logic [15:0] cfg_data = '0;
   logic [1:0] open_line = '0, overtemp = '0, dac_en, led;
   logic [1:0][7:0] health;
   int n_errors = 0, tests_run = 0;

   cso_link_if i_cso_link_if();
   cso_host #(.CYCLE_CYCLES(10)) i_cso_host (.i_ref_clk(clk),
      .i_arst_n(rst_n), .i_ce(host_ce), .i_start(start),
      .i_restart(restart), .i_value(value), .i_cfg_req(cfg_req),
      .i_cfg_addr(cfg_addr), .i_cfg_data(cfg_data), .o_cfg_ready(),
      .o_cfg_refused(cfg_refused), .o_health(health),
      .o_module_ok(module_ok), .o_cycle_strobe(),
      .lnk(i_cso_link_if.host));
   cso_device #(.LOSS_CYCLES(50)) i_cso_device (.i_ref_clk(clk),
      .i_arst_n(rst_n), .i_ce(1'b1), .lnk(i_cso_link_if.device),
      .i_open_line(open_line), .i_overtemp(overtemp),
      .i_supply_fault(supply), .o_dac_code(dac), .o_dac_en(dac_en),
      .o_ch_led(led), .o_failsafe_active(fs_act));
   cso_link_monitor #(.LOSS_CYCLES(50)) i_cso_link_monitor (
      .i_ref_clk(clk), .i_arst_n(rst_n),
      .cyc_valid(i_cso_link_if.cyc_valid), .value(i_cso_link_if.value),
      .fs_ctrl(i_cso_link_if.fs_ctrl), .cfg_wr(i_cso_link_if.cfg_wr),
      .cfg_addr(i_cso_link_if.cfg_addr),
      .cfg_wdata(i_cso_link_if.cfg_wdata),
      .health(i_cso_link_if.health), .module_ok(i_cso_link_if.module_ok));

   // ****************************************************************
   // helpers
   // ****************************************************************
   // expected converter code from scaling mode and demand
   function automatic logic [15:0] scl(input logic [7:0] m,
      input logic [15:0] v);
      logic [33:0] p;
      if (m[7]) p = (v * CSO_K_020U) >> 16;
      else if (m[6]) p = (v * CSO_K_024) >> 16;
      else if (m[4]) p = (v * CSO_K_020) >> 15;
      else p = CSO_DAC_4MA + ((v * CSO_K_420) >> 15);
      // full scale is the top code; a product past it must not wrap
      return (p > 34'h0ffff) ? 16'hffff : p[15:0];
   endfunction : scl
   // one config write; holds the request across the taking edge
   task automatic cfg(input logic [8:0] a, input logic [15:0] d);
      cfg_req = 1'b1;
      cfg_addr = a;
      cfg_data = d;
      @(negedge clk);
      cfg_req = 1'b0;
      refd = cfg_refused;
      repeat (2) @(negedge clk);
   endtask : cfg
   task automatic frames(input int n);
      repeat (n * 10) @(negedge clk);
   endtask : frames
   // one-cycle run control pulse: 1 restart, 0 start
   task automatic kick(input logic rs);
      if (rs) restart = 1'b1;
      else start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      restart = 1'b0;
   endtask : kick
   task automatic print_verdict;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   initial begin
      forever #5 clk = ~clk;
   end
   // hang guard, far beyond the few thousand cycles of the run
   initial begin
      #200000;
      n_errors++;
      $display("ERROR at %0t: watchdog expired", $time);
      print_verdict();
   end

   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      `CHK(module_ok, 1'b0)
      `CHK(dac_en, 2'b11)
      cfg(CSO_ADR_FSVAL[0], 16'h1000);
      frames(3);
      `CHK(dac[0], scl(8'h21, 16'h0000))
      kick(1'b0);
      foreach (rows[k]) begin
         cfg(CSO_ADR_MODE[0], rows[k].m);
         value[0] = rows[k].v;
         frames(3);
         `CHK(dac[0], rows[k].d)
         `CHK(led[0], rows[k].l)
         `CHK(dac_en[0], rows[k].m[0])
      end
      // static substitute, held until a normal frame
      value[0] = 16'h2000;
      frames(3);
      kick(1'b1);
      frames(3);
      `CHK(fs_act, 1'b1)
      `CHK(dac[0], scl(8'h21, 16'h1000))
      value[0] = 16'h3000;
      frames(3);
      `CHK(dac[0], scl(8'h21, 16'h1000))
      kick(1'b0);
      frames(3);
      `CHK(dac[0], scl(8'h21, 16'h3000))
      // hold-last mode entered by a silent link
      cfg(CSO_ADR_FSMODE[0], 16'h0001);
      host_ce = 1'b0;
      repeat (80) @(negedge clk);
      `CHK(fs_act, 1'b1)
      `CHK(dac[0], scl(8'h21, 16'h3000))
      value[0] = 16'h0100;
      host_ce = 1'b1;
      frames(3);
      `CHK(module_ok, 1'b1)
      `CHK(dac[0], scl(8'h21, 16'h0100))
      // health flags, then checking turned off on channel 1
      open_line = 2'b01;
      overtemp = 2'b10;
      supply = 1'b1;
      frames(2);
      `CHK(health[0], 8'h84)
      `CHK(health[1], 8'h88)
      cfg(CSO_ADR_MODE[1], 16'h0023);
      frames(2);
      `CHK(health[1], 8'h80)
      cfg(CSO_ADR_MODE[1], 16'h0031);
      `CHK(refd, 1'b1)
      // ramp of 128 per step at the fastest rate, then a plain jump
      cfg(CSO_ADR_SLEW[1], 16'h8007);
      value[1] = 16'h0400;
      frames(5);
      `CHK(dac[1] == scl(8'h23, 16'h0400), 1'b0)
      repeat (3600) @(negedge clk);
      `CHK(dac[1], scl(8'h23, 16'h0400))
      cfg(CSO_ADR_SLEW[1], 16'h0007);
      value[1] = 16'h0000;
      frames(3);
      `CHK(dac[1], scl(8'h23, 16'h0000))
      // reset in mid-run: idle again, no start until the bit is sent
      rst_n = 1'b0;
      @(negedge clk);
      `CHK(fs_act, 1'b0)
      `CHK(health[1], 8'h00)
      rst_n = 1'b1;
      frames(2);
      `CHK(module_ok, 1'b0)
      `CHK(dac[0], scl(8'h21, 16'h0000))
      print_verdict();
   end
endmodule : current_output_slew_fallback_test
